// *** rtl/pbi_defines.svh ***
/*
 * register offsets, field positions, reset values and timing counts
 * of the push-button and system event interrupt block.
 * assumes a 50 MHz core clock.
 */
`ifndef PBI_DEFINES_SVH
`define PBI_DEFINES_SVH

`define PBI_ADDR_BTN_STATUS   8'h24
`define PBI_ADDR_BTN_MASK     8'h25
`define PBI_ADDR_BTN_SENSE    8'h26
`define PBI_ADDR_MISC_STATUS  8'h28
`define PBI_ADDR_MISC_MASK    8'h29
`define PBI_ADDR_MISC_SENSE   8'h2a

`define PBI_BTN_BITS          6
`define PBI_MISC_BITS         5
`define PBI_BTN_MASK_RESET    6'h3f
`define PBI_MISC_MASK_RESET   5'h1f

`define PBI_BIT_PRESS         0
`define PBI_BIT_WAKE_DONE     0
`define PBI_BIT_SLEEP_DONE    1
`define PBI_BIT_POWER_KEY     2
`define PBI_BIT_SUPPLY_LOW    3
`define PBI_BIT_SUPPLY_OVER   4

// hold time unit and derived clock count
`define PBI_CLK_HZ            50000000
`define PBI_HOLD_UNIT_MS      1000
`define PBI_TICKS_PER_SEC     ((`PBI_CLK_HZ / 1000) * `PBI_HOLD_UNIT_MS)
`define PBI_SEC_CNT_W         26
`define PBI_HOLD_CNT_W        4

`endif

// *** rtl/pbi_pkg.sv ***
/*
 * types of the push-button and system event interrupt block.
 * assumes pbi_defines.svh is available on the include path.
 */
`include "pbi_defines.svh"

package pbi_pkg;

    typedef struct packed {
        logic [`PBI_BTN_BITS-1:0]   btn_status;
        logic [`PBI_BTN_BITS-1:0]   btn_mask;
        logic [`PBI_BTN_BITS-1:0]   btn_sense;
        logic [`PBI_MISC_BITS-1:0]  misc_status;
        logic [`PBI_MISC_BITS-1:0]  misc_mask;
        logic [`PBI_SEC_CNT_W-1:0]  sec_cnt;
        logic [`PBI_HOLD_CNT_W-1:0] hold_secs;
        logic [7:0]                 rdata;
        logic                       irq_out_n;
    } pbi_state_type;

endpackage

// *** rtl/pbi_irq.sv ***
/*
 * push-button and system event interrupt block: status, mask and sense
 * registers, hold-time measurement and the active-low interrupt pin.
 * assumes a byte register port from the control-interface slave, a
 * debounced button level and one-cycle event pulses from the sequencer
 * and supply comparators, all synchronous to clk.
 */
// How it works
// - button status clears on read or write-1
// - mask 0 lets set status pull pin low
// - mask 1 blocks pin, status still records
// - six button masks reset to 1, bits 7:6 unused
// - press sense follows debounced button level
// - hold1 sense set after one second held
// - hold senses clear when press sense clears
// - hold2/3/4/8 senses after 2,3,4,8 seconds
// - button senses reset 0, read only
// - wake transition completion sets misc bit 0
// - sleep transition completion sets misc bit 1
// - power key event sets misc bit 2
// - low supply crossing sets misc bit 3
// - supply over-voltage crossing sets misc bit 4
// - misc status reset 0, clears on read or write-1
// - press status sets on every sense change
// - hold status sets when hold reached
// - misc masks reset 1, gate pin likewise
`timescale 1ns/1ns
`include "pbi_defines.svh"

module pbi_irq (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic       press_level,
    input  wire logic       wake_done,
    input  wire logic       sleep_done,
    input  wire logic       power_key_input,
    input  wire logic       supply_low_threshold,
    input  wire logic       supply_over_threshold,
    output logic            irq_out_n
);

    // ==================================================================
    // state
    // ==================================================================
    pbi_pkg::pbi_state_type r;
    pbi_pkg::pbi_state_type next_r;

    logic [`PBI_BTN_BITS-1:0]  hold_reached;
    logic [`PBI_BTN_BITS-1:0]  btn_clear;
    logic [`PBI_MISC_BITS-1:0] misc_event;
    logic [`PBI_MISC_BITS-1:0] misc_clear;
    logic                      sec_tick;
    logic                      pending;

    // ==================================================================
    // hold thresholds, one per sense bit above press
    // ==================================================================
    localparam logic [`PBI_HOLD_CNT_W-1:0] HOLD1 = 4'h1;
    localparam logic [`PBI_HOLD_CNT_W-1:0] HOLD2 = 4'h2;
    localparam logic [`PBI_HOLD_CNT_W-1:0] HOLD3 = 4'h3;
    localparam logic [`PBI_HOLD_CNT_W-1:0] HOLD4 = 4'h4;
    localparam logic [`PBI_HOLD_CNT_W-1:0] HOLD8 = 4'h8;
    localparam logic [`PBI_SEC_CNT_W-1:0]  SEC_LAST =
        `PBI_SEC_CNT_W'(`PBI_TICKS_PER_SEC - 1);

    assign sec_tick = r.btn_sense[`PBI_BIT_PRESS] && (r.sec_cnt == SEC_LAST);

    // held longer than n seconds: n full seconds elapsed and still held
    always_comb begin
        hold_reached    = '0;
        hold_reached[1] = r.hold_secs >= HOLD1;
        hold_reached[2] = r.hold_secs >= HOLD2;
        hold_reached[3] = r.hold_secs >= HOLD3;
        hold_reached[4] = r.hold_secs >= HOLD4;
        hold_reached[5] = r.hold_secs >= HOLD8;
    end

    // ==================================================================
    // event sources and host clears
    // ==================================================================
    always_comb begin
        misc_event = '0;
        misc_event[`PBI_BIT_WAKE_DONE]   = wake_done;
        misc_event[`PBI_BIT_SLEEP_DONE]  = sleep_done;
        misc_event[`PBI_BIT_POWER_KEY]   = power_key_input;
        misc_event[`PBI_BIT_SUPPLY_LOW]  = supply_low_threshold;
        misc_event[`PBI_BIT_SUPPLY_OVER] = supply_over_threshold;
    end

    // button status: read clears all, write-1 clears selected bits
    always_comb begin
        btn_clear = '0;
        if (reg_addr == `PBI_ADDR_BTN_STATUS) begin
            if (reg_rd) begin
                btn_clear = '1;
            end else if (reg_wr) begin
                btn_clear = reg_wdata[`PBI_BTN_BITS-1:0];
            end
        end
    end

    // misc status: write-1 clears, read also clears like its neighbours
    always_comb begin
        misc_clear = '0;
        if (reg_addr == `PBI_ADDR_MISC_STATUS) begin
            if (reg_rd) begin
                misc_clear = '1;
            end else if (reg_wr) begin
                misc_clear = reg_wdata[`PBI_MISC_BITS-1:0];
            end
        end
    end

    // unmasked pending status pulls the pin low
    assign pending = |(r.btn_status & ~r.btn_mask) |
                     |(r.misc_status & ~r.misc_mask);

    // ==================================================================
    // next state
    // ==================================================================
    always_comb begin
        next_r = r;

        // press sense follows debounced level; hold counters run meanwhile
        next_r.btn_sense[`PBI_BIT_PRESS] = press_level;
        if (!r.btn_sense[`PBI_BIT_PRESS]) begin
            next_r.sec_cnt   = '0;
            next_r.hold_secs = '0;
        end else if (sec_tick) begin
            next_r.sec_cnt = '0;
            if (r.hold_secs != HOLD8) begin
                next_r.hold_secs = r.hold_secs + 4'h1;
            end
        end else begin
            next_r.sec_cnt = r.sec_cnt + `PBI_SEC_CNT_W'(1);
        end
        // hold senses drop with press sense
        next_r.btn_sense[`PBI_BTN_BITS-1:1] =
            r.btn_sense[`PBI_BIT_PRESS] ?
            hold_reached[`PBI_BTN_BITS-1:1] : '0;

        // sticky status, set wins over clear
        next_r.btn_status = r.btn_status & ~btn_clear;
        if (press_level != r.btn_sense[`PBI_BIT_PRESS]) begin
            next_r.btn_status[`PBI_BIT_PRESS] = 1'b1;
        end
        next_r.btn_status[`PBI_BTN_BITS-1:1] =
            next_r.btn_status[`PBI_BTN_BITS-1:1] |
            (next_r.btn_sense[`PBI_BTN_BITS-1:1] &
             ~r.btn_sense[`PBI_BTN_BITS-1:1]);
        next_r.misc_status = (r.misc_status & ~misc_clear) |
                             misc_event;

        // mask writes
        if (reg_wr && reg_addr == `PBI_ADDR_BTN_MASK) begin
            next_r.btn_mask = reg_wdata[`PBI_BTN_BITS-1:0];
        end
        if (reg_wr && reg_addr == `PBI_ADDR_MISC_MASK) begin
            next_r.misc_mask = reg_wdata[`PBI_MISC_BITS-1:0];
        end

        // read data, registered one cycle after the read strobe
        if (reg_rd) begin
            unique case (reg_addr)
                `PBI_ADDR_BTN_STATUS:  next_r.rdata = {2'h0, r.btn_status};
                `PBI_ADDR_BTN_MASK:    next_r.rdata = {2'h0, r.btn_mask};
                `PBI_ADDR_BTN_SENSE:   next_r.rdata = {2'h0, r.btn_sense};
                `PBI_ADDR_MISC_STATUS: next_r.rdata = {3'h0, r.misc_status};
                `PBI_ADDR_MISC_MASK:   next_r.rdata = {3'h0, r.misc_mask};
                `PBI_ADDR_MISC_SENSE:  next_r.rdata =
                    {3'h0, supply_over_threshold, supply_low_threshold,
                     power_key_input, sleep_done, wake_done};
                default:               next_r.rdata = 8'h00;
            endcase
        end

        next_r.irq_out_n = !pending;
    end

    // ==================================================================
    // registers
    // ==================================================================
    always_ff @(posedge clk) begin
        if (!rstn) begin
            r             <= '0;
            r.btn_mask    <= `PBI_BTN_MASK_RESET;
            r.misc_mask   <= `PBI_MISC_MASK_RESET;
            r.irq_out_n   <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata = r.rdata;
    assign irq_out_n = r.irq_out_n;

    // ==================================================================
    // checks
    // ==================================================================
    a_pin_follows_pending: assert property (
        @(posedge clk) disable iff (!rstn)
        pending |=> !irq_out_n)
        else $error("pin not low with unmasked status");

    a_masked_no_irq: assert property (
        @(posedge clk) disable iff (!rstn)
        !pending |=> irq_out_n)
        else $error("pin low with nothing unmasked");

    a_w1c_button: assert property (
        @(posedge clk) disable iff (!rstn)
        (reg_wr && reg_addr == `PBI_ADDR_BTN_STATUS && reg_wdata[1] &&
         !(hold_reached[1] && r.btn_sense[0] && !r.btn_sense[1]))
        |=> !r.btn_status[1])
        else $error("button status bit not cleared by write 1");

    a_read_clear: assert property (
        @(posedge clk) disable iff (!rstn)
        (reg_rd && reg_addr == `PBI_ADDR_BTN_STATUS &&
         press_level == r.btn_sense[0]) |=> !r.btn_status[0])
        else $error("press status not cleared by read");

    a_press_change: assert property (
        @(posedge clk) disable iff (!rstn)
        (press_level != r.btn_sense[0]) |=> r.btn_status[0])
        else $error("press status missed a sense change");

    a_release_clears: assert property (
        @(posedge clk) disable iff (!rstn)
        !r.btn_sense[0] |=> r.btn_sense[5:1] == 5'h00)
        else $error("hold sense kept after release");

    a_misc_event_set: assert property (
        @(posedge clk) disable iff (!rstn)
        wake_done |=> r.misc_status[0])
        else $error("wake completion not recorded");

    a_hold_status: assert property (
        @(posedge clk) disable iff (!rstn)
        $rose(r.btn_sense[1]) |-> r.btn_status[1])
        else $error("hold status not set with sense");

    a_mask_reset: assert property (
        @(posedge clk)
        !rstn |=> r.btn_mask == 6'h3f && r.misc_mask == 5'h1f)
        else $error("masks not reset to ones");

    a_status_reset: assert property (
        @(posedge clk)
        !rstn |=> r.misc_status == 5'h00 && r.btn_status == 6'h00 &&
                  r.btn_sense == 6'h00)
        else $error("status or sense not reset to zero");

    a_press_sense_set: assert property (
        @(posedge clk) disable iff (!rstn)
        press_level |=> r.btn_sense[0])
        else $error("press sense missed a press");

    a_press_sense_clr: assert property (
        @(posedge clk) disable iff (!rstn)
        !press_level |=> !r.btn_sense[0])
        else $error("press sense missed a release");

    a_hold1_sense: assert property (
        @(posedge clk) disable iff (!rstn)
        (r.btn_sense[0] && r.hold_secs >= HOLD1) |=> r.btn_sense[1])
        else $error("one second hold sense missing");

    a_hold2_sense: assert property (
        @(posedge clk) disable iff (!rstn)
        (r.btn_sense[0] && r.hold_secs >= HOLD2) |=> r.btn_sense[2])
        else $error("two second hold sense missing");

    a_hold3_sense: assert property (
        @(posedge clk) disable iff (!rstn)
        (r.btn_sense[0] && r.hold_secs >= HOLD3) |=> r.btn_sense[3])
        else $error("three second hold sense missing");

    a_hold4_sense: assert property (
        @(posedge clk) disable iff (!rstn)
        (r.btn_sense[0] && r.hold_secs >= HOLD4) |=> r.btn_sense[4])
        else $error("four second hold sense missing");

    a_hold8_sense: assert property (
        @(posedge clk) disable iff (!rstn)
        (r.btn_sense[0] && r.hold_secs >= HOLD8) |=> r.btn_sense[5])
        else $error("eight second hold sense missing");

    a_hold_early: assert property (
        @(posedge clk) disable iff (!rstn)
        r.hold_secs == 4'h0 |=> r.btn_sense[5:1] == 5'h00)
        else $error("hold sense before a full second");

    a_hold_idle: assert property (
        @(posedge clk) disable iff (!rstn)
        !r.btn_sense[0] |=> r.hold_secs == 4'h0 && r.sec_cnt == '0)
        else $error("hold timer kept running after release");

    a_sleep_event_set: assert property (
        @(posedge clk) disable iff (!rstn)
        sleep_done |=> r.misc_status[1])
        else $error("sleep completion not recorded");

    a_key_event_set: assert property (
        @(posedge clk) disable iff (!rstn)
        power_key_input |=> r.misc_status[2])
        else $error("power key event not recorded");

    a_low_event_set: assert property (
        @(posedge clk) disable iff (!rstn)
        supply_low_threshold |=> r.misc_status[3])
        else $error("low supply crossing not recorded");

    a_over_event_set: assert property (
        @(posedge clk) disable iff (!rstn)
        supply_over_threshold |=> r.misc_status[4])
        else $error("supply over-voltage not recorded");

    a_btn_sticky: assert property (
        @(posedge clk) disable iff (!rstn)
        (r.btn_status[0] && !(reg_addr == `PBI_ADDR_BTN_STATUS &&
         (reg_rd || (reg_wr && reg_wdata[0])))) |=> r.btn_status[0])
        else $error("press status lost without a clear");

    a_misc_sticky: assert property (
        @(posedge clk) disable iff (!rstn)
        (r.misc_status[0] && !(reg_addr == `PBI_ADDR_MISC_STATUS &&
         (reg_rd || (reg_wr && reg_wdata[0])))) |=> r.misc_status[0])
        else $error("wake status lost without a clear");

    a_misc_w1c: assert property (
        @(posedge clk) disable iff (!rstn)
        (reg_wr && !reg_rd && reg_addr == `PBI_ADDR_MISC_STATUS &&
         misc_event == 5'h00)
        |=> (r.misc_status & $past(reg_wdata[4:0])) == 5'h00)
        else $error("misc status not cleared by write 1");

    a_btn_mask_write: assert property (
        @(posedge clk) disable iff (!rstn)
        (reg_wr && reg_addr == `PBI_ADDR_BTN_MASK)
        |=> r.btn_mask == $past(reg_wdata[5:0]))
        else $error("button mask write lost");

    a_misc_mask_write: assert property (
        @(posedge clk) disable iff (!rstn)
        (reg_wr && reg_addr == `PBI_ADDR_MISC_MASK)
        |=> r.misc_mask == $past(reg_wdata[4:0]))
        else $error("misc mask write lost");

    a_all_masked_idle: assert property (
        @(posedge clk) disable iff (!rstn)
        (&r.btn_mask && &r.misc_mask) |=> irq_out_n)
        else $error("pin low with every source masked");

    a_press_unmasked: assert property (
        @(posedge clk) disable iff (!rstn)
        (r.btn_status[0] && !r.btn_mask[0]) |=> !irq_out_n)
        else $error("unmasked press status left pin high");

endmodule

// *** sim/pbi_host.sv ***
/* host model of the button event block: byte register master.
   assumes strobes are sampled on the rising edge of clk. */
`timescale 1ns/1ns
module pbi_host (
    input  wire logic       clk,
    output logic      [7:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // ==========
    // register access
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end
    // one strobe edge, then scramble the released lines
    task automatic access(input logic [7:0] a, input logic w,
                          input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = w;
        reg_rd    = !w;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
        q         = reg_rdata;
    endtask
endmodule

// *** sim/testbench.sv ***
/* self-checking bench of the button event block.
   assumes the host model in pbi_host drives the register port. */
`timescale 1ns/1ns
module testbench;
    logic       clk;
    logic       rstn;
    logic [7:0] reg_addr;
    logic       reg_wr;
    logic       reg_rd;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       press_level;
    logic [4:0] ev;
    logic       irq_out_n;
    logic [7:0] q;
    int         miscompares = 0;
    int         num_checks = 0;
    int         cycles = 0;
    pbi_irq i_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .press_level(press_level),
        .wake_done(ev[0]), .sleep_done(ev[1]), .power_key_input(ev[2]),
        .supply_low_threshold(ev[3]), .supply_over_threshold(ev[4]),
        .irq_out_n(irq_out_n));
    pbi_host i_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========
    // helpers
    task automatic chk(input string n, input logic [7:0] s,
                       input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_host.access(a, 1'b1, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        i_host.access(a, 1'b0, 8'h00, q);
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    function automatic logic [7:0] pin();
        return {7'h00, irq_out_n};
    endfunction
    task automatic pulse(input logic [4:0] e);
        @(negedge clk);
        ev = e;
        @(negedge clk);
        ev = 5'h00;
    endtask
    // ==========
    // scenarios
    task automatic t_reset;
        logic [7:0] ra [6] = '{8'h25, 8'h29, 8'h24, 8'h26, 8'h28, 8'h27};
        logic [7:0] rv [6] = '{8'h3f, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rd(ra[i]);
            chk("reset value", q, rv[i]);
        end
        chk("reset pin", pin(), 8'h01);
        $display("reset test done");
    endtask
    task automatic t_misc;
        logic [7:0] b;
        for (int i = 0; i < 5; i++) begin
            b = 8'h01 << i;
            pulse(b[4:0]);
            tick(2);
            chk("masked pin", pin(), 8'h01);
            wr(8'h29, ~b & 8'h1f);
            tick(2);
            chk("unmasked pin", pin(), 8'h00);
            wr(8'h28, ~b);
            rd(8'h28);
            chk("misc status", q, b);
            tick(2);
            chk("cleared pin", pin(), 8'h01);
            pulse(b[4:0]);
            wr(8'h28, b);
            rd(8'h28);
            chk("misc w1c", q, 8'h00);
            wr(8'h29, 8'hff);
        end
        rd(8'h29);
        chk("misc mask", q, 8'h1f);
        $display("misc test done");
    endtask
    task automatic t_button;
        wr(8'h25, 8'h3e);
        press_level = 1'b1;
        tick(3);
        chk("press pin", pin(), 8'h00);
        wr(8'h26, 8'hff);
        rd(8'h26);
        chk("sense pressed", q, 8'h01);
        wr(8'h24, 8'h00);
        rd(8'h24);
        chk("press status", q, 8'h01);
        tick(2);
        chk("pin after read", pin(), 8'h01);
        press_level = 1'b0;
        tick(3);
        chk("release pin", pin(), 8'h00);
        rd(8'h26);
        chk("sense released", q, 8'h00);
        wr(8'h24, 8'h3f);
        rd(8'h24);
        chk("btn w1c", q, 8'h00);
        wr(8'h25, 8'hff);
        rd(8'h25);
        chk("btn mask", q, 8'h3f);
        press_level = 1'b1;
        tick(3);
        chk("masked press", pin(), 8'h01);
        rd(8'h24);
        chk("masked status", q, 8'h01);
        press_level = 1'b0;
        $display("button test done");
    endtask
    task automatic wrap_up;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        press_level = 1'b0;
        ev = 5'h00;
        tick(2);
        rstn = 1'b1;
        t_reset();
        t_misc();
        t_button();
        wrap_up();
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            wrap_up();
        end
    end
endmodule
